// *** rtl/periph_irq_dma_dev.sv ***
// Device end: interrupt status word, DMA reason bits and DMA burst request counter.
`timescale 1ns/100ps
// Function
// - Burst length is 13 bits, top three reserved.
// - Host loads even burst length in wide mode.
// - Host picks burst dividing buffer transfer count.
// - Request drops when bytes moved reach length.
// - Host writes reserved bits with reset value.
// - Status bit sets on its hardware event.
// - Interrupt high while status word non-zero.
// - Host reads status word after interrupt.
// - Each endpoint has transmit and receive bits.
// - Bus state events set their status bits.
// - One DMA bit, causes in reason register.
// - Writing one clears a bit, zero keeps; the DMA bit clears only once the reason bits are all zero.
// - Host clears cause and DMA bit together.
// - Fixed status bit layout, top bits reserved.
module periph_irq_dma_dev (
  input  wire logic                                 SYS_CLK,
  input  wire logic                                 RST_N,
  irq_dma_link_if.device_mp                         LINK,
  input  wire logic [periph_irq_pkg::EP_COUNT-1:0]  EP_TX_EVENT,
  input  wire logic [periph_irq_pkg::EP_COUNT-1:0]  EP_RX_EVENT,
  input  wire logic                                 SETUP_EVENT,
  input  wire logic                                 BUS_RESET_EVENT,
  input  wire logic                                 SOF_EVENT,
  input  wire logic                                 PSEUDO_FRAME_START_EVENT_EVENT,
  input  wire logic                                 SUSPEND_EVENT,
  input  wire logic                                 RESUME_EVENT,
  input  wire logic                                 HS_STAT_EVENT,
  input  wire logic                                 VBUS_EVENT,
  input  wire logic [periph_irq_pkg::REASON_W-1:0]  DMA_CAUSE_EVENT,
  input  wire logic                                 DMA_ACTIVE,
  output logic                                      BURST_DONE
);
  import periph_irq_pkg::*;

  logic [DATA_W-1:0]        status_ff;
  logic [DATA_W-1:0]        nxt_status;
  logic [REASON_W-1:0]      reason_ff;
  logic [REASON_W-1:0]      nxt_reason;
  logic [BURST_REG_W-1:0]   burst_ff;
  logic [BURST_REG_W-1:0]   nxt_burst;
  logic                     irq_ff;
  logic                     nxt_irq;
  logic [DATA_W-1:0]        rdata_ff;
  logic [DATA_W-1:0]        nxt_rdata;
  logic                     rvalid_ff;
  logic                     nxt_rvalid;
  dma_state_type            dma_state_ff;
  dma_state_type            nxt_dma_state;
  logic [BURST_FIELD_W-1:0] count_ff;
  logic [BURST_FIELD_W-1:0] nxt_count;
  logic                     req_ff;
  logic                     nxt_req;
  logic                     done_ff;
  logic                     nxt_done;
  logic [DATA_W-1:0]        set_vec;
  logic [DATA_W-1:0]        clr_vec;
  logic [DATA_W-1:0]        reason_clr;
  logic [BURST_FIELD_W-1:0] burst_len;
  logic [BURST_FIELD_W-1:0] step;
  logic [BURST_FIELD_W:0]   moved;

  // Clears the bits written with one, then applies new events so a set wins.
  function automatic logic [DATA_W-1:0] clear_then_set(
    input logic [DATA_W-1:0] cur,
    input logic [DATA_W-1:0] set,
    input logic [DATA_W-1:0] clr
  );
    clear_then_set = (cur & ~clr) | set;
  endfunction

  // Register address match for a write strobe.
  function automatic logic write_hit(
    input logic              wr,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    write_hit = wr && (addr == offset);
  endfunction

  assign burst_len = burst_ff[BURST_FIELD_W-1:0];

  // Collects the hardware events into their status positions.
  always_comb begin
    set_vec                = '0;
    set_vec[BUS_RESET_BIT] = BUS_RESET_EVENT;
    set_vec[SOF_BIT]       = SOF_EVENT;
    set_vec[PSEUDO_FRAME_START_EVENT_BIT]      = PSEUDO_FRAME_START_EVENT_EVENT;
    set_vec[SUSPEND_BIT]   = SUSPEND_EVENT;
    set_vec[RESUME_BIT]    = RESUME_EVENT;
    set_vec[HS_STAT_BIT]   = HS_STAT_EVENT;
    set_vec[VBUS_BIT]      = VBUS_EVENT;
    set_vec[SETUP_BIT]     = SETUP_EVENT;
    set_vec[DMA_BIT]       = |DMA_CAUSE_EVENT;
    for (int i = 0; i < EP_COUNT; i++) begin
      set_vec[EP_RX_BIT0 + EP_BIT_STRIDE * i] = EP_RX_EVENT[i];
      set_vec[EP_TX_BIT0 + EP_BIT_STRIDE * i] = EP_TX_EVENT[i];
    end
  end

  // Status word, reason bits, burst register and read port.
  always_comb begin
    clr_vec    = '0;
    reason_clr = '0;
    nxt_burst  = burst_ff;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = 1'b0;
    if (write_hit(LINK.reg_wr, LINK.reg_addr, STATUS_OFFSET)) begin
      clr_vec = LINK.reg_wdata & STATUS_VALID_MASK;
    end
    if (write_hit(LINK.reg_wr, LINK.reg_addr, REASON_OFFSET)) begin
      reason_clr = LINK.reg_wdata;
    end
    if (write_hit(LINK.reg_wr, LINK.reg_addr, BURST_OFFSET)) begin
      nxt_burst = BURST_REG_W'(LINK.reg_wdata[BURST_FIELD_W-1:0]);
    end
    nxt_reason = REASON_W'(clear_then_set(DATA_W'(reason_ff), DATA_W'(DMA_CAUSE_EVENT),
                                          reason_clr));
    nxt_status = clear_then_set(status_ff, set_vec, clr_vec) & STATUS_VALID_MASK;
    nxt_status[DMA_BIT] = set_vec[DMA_BIT] |
                          (status_ff[DMA_BIT] & ~(clr_vec[DMA_BIT] & (nxt_reason == '0)));
    nxt_irq = (nxt_status != '0);
    if (LINK.reg_rd) begin
      nxt_rvalid = 1'b1;
      case (LINK.reg_addr)
        STATUS_OFFSET: nxt_rdata = status_ff;
        REASON_OFFSET: nxt_rdata = DATA_W'(reason_ff);
        BURST_OFFSET:  nxt_rdata = DATA_W'(burst_ff);
        default:       nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      status_ff <= STATUS_RESET;
      reason_ff <= REASON_RESET;
      burst_ff  <= BURST_RESET;
      irq_ff    <= 1'b0;
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      reason_ff <= nxt_reason;
      burst_ff  <= nxt_burst;
      irq_ff    <= nxt_irq;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Burst counter: each acknowledge moves one byte, or two on the wide bus.
  always_comb begin
    step          = LINK.bus_wide ? STEP_WIDE : STEP_NARROW;
    moved         = (BURST_FIELD_W + 1)'(count_ff) + (BURST_FIELD_W + 1)'(step);
    nxt_dma_state = dma_state_ff;
    nxt_count     = count_ff;
    nxt_req       = req_ff;
    nxt_done      = 1'b0;
    case (dma_state_ff)
      DMA_IDLE: begin
        if (DMA_ACTIVE && (burst_len != '0)) begin
          nxt_req       = 1'b1;
          nxt_count     = '0;
          nxt_dma_state = DMA_BURST;
        end
      end
      DMA_BURST: begin
        if (!DMA_ACTIVE) begin
          nxt_req       = 1'b0;
          nxt_count     = '0;
          nxt_dma_state = DMA_IDLE;
        end else if (LINK.dma_ack) begin
          if (moved >= (BURST_FIELD_W + 1)'(burst_len)) begin
            nxt_req       = 1'b0;
            nxt_done      = 1'b1;
            nxt_count     = '0;
            nxt_dma_state = DMA_GAP;
          end else begin
            nxt_count = moved[BURST_FIELD_W-1:0];
          end
        end
      end
      DMA_GAP: begin
        nxt_dma_state = DMA_IDLE;
      end
      default: begin
        nxt_req       = 1'b0;
        nxt_count     = '0;
        nxt_dma_state = DMA_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      dma_state_ff <= DMA_IDLE;
      count_ff     <= '0;
      req_ff       <= 1'b0;
      done_ff      <= 1'b0;
    end else begin
      dma_state_ff <= nxt_dma_state;
      count_ff     <= nxt_count;
      req_ff       <= nxt_req;
      done_ff      <= nxt_done;
    end
  end

  assign LINK.reg_rdata        = rdata_ff;
  assign LINK.reg_rvalid       = rvalid_ff;
  assign LINK.irq              = irq_ff;
  assign LINK.dma_request_line = req_ff;
  assign BURST_DONE            = done_ff;

endmodule

// *** rtl/periph_irq_pkg.sv ***
// Shared constants and types for the peripheral interrupt and DMA burst blocks.
package periph_irq_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          EP_COUNT        = 8;
  localparam int          REASON_W        = 8;
  localparam int          BURST_REG_W     = 16;
  localparam int          BURST_FIELD_W   = 13;

  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h18;
  localparam logic [ADDR_W-1:0] REASON_OFFSET = 8'h50;
  localparam logic [ADDR_W-1:0] BURST_OFFSET  = 8'h64;

  localparam int          BUS_RESET_BIT   = 0;
  localparam int          SOF_BIT         = 1;
  localparam int          PSEUDO_FRAME_START_EVENT_BIT        = 2;
  localparam int          SUSPEND_BIT     = 3;
  localparam int          RESUME_BIT      = 4;
  localparam int          HS_STAT_BIT     = 5;
  localparam int          DMA_BIT         = 6;
  localparam int          VBUS_BIT        = 7;
  localparam int          SETUP_BIT       = 8;
  localparam int          EP_RX_BIT0      = 10;
  localparam int          EP_TX_BIT0      = 11;
  localparam int          EP_BIT_STRIDE   = 2;

  localparam logic [DATA_W-1:0]        STATUS_VALID_MASK = 32'h03ff_fdff;
  localparam logic [DATA_W-1:0]        STATUS_RESET      = 32'h0000_0000;
  localparam logic [REASON_W-1:0]      REASON_RESET      = 8'h00;
  localparam logic [BURST_REG_W-1:0]   BURST_RESET       = 16'h0000;
  localparam logic [BURST_FIELD_W-1:0] BURST_EVEN_MASK   = 13'h1ffe;
  localparam logic [BURST_FIELD_W-1:0] STEP_NARROW       = 13'h0001;
  localparam logic [BURST_FIELD_W-1:0] STEP_WIDE         = 13'h0002;

  typedef enum logic [1:0] {
    DMA_IDLE  = 2'b00,
    DMA_BURST = 2'b01,
    DMA_GAP   = 2'b11
  } dma_state_type;

  typedef enum logic [1:0] {
    HOST_IDLE   = 2'b00,
    HOST_REASON = 2'b01,
    HOST_ISSUE  = 2'b11,
    HOST_WAIT   = 2'b10
  } host_state_type;

endpackage

// *** rtl/irq_dma_link_if.sv ***
// Register access, interrupt and DMA handshake signals between processor side and device.
`timescale 1ns/100ps
interface irq_dma_link_if;
  import periph_irq_pkg::*;

  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_rvalid;
  logic              bus_wide;
  logic              irq;
  logic              dma_request_line;
  logic              dma_ack;

  modport device_mp (
    input  reg_addr,
    input  reg_wdata,
    input  reg_wr,
    input  reg_rd,
    input  bus_wide,
    input  dma_ack,
    output reg_rdata,
    output reg_rvalid,
    output irq,
    output dma_request_line
  );

  modport host_mp (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    output bus_wide,
    output dma_ack,
    input  reg_rdata,
    input  reg_rvalid,
    input  irq,
    input  dma_request_line
  );
endinterface

// *** rtl/periph_irq_dma_host.sv ***
// Processor and DMA master end: register commands, interrupt service and DMA acknowledges.
`timescale 1ns/100ps
module periph_irq_dma_host (
  input  wire logic                                 SYS_CLK,
  input  wire logic                                 RST_N,
  irq_dma_link_if.host_mp                           LINK,
  input  wire logic                                 WIDE_BUS,
  input  wire logic                                 CMD_VALID,
  input  wire logic                                 CMD_WRITE,
  input  wire logic [periph_irq_pkg::ADDR_W-1:0]    CMD_ADDR,
  input  wire logic [periph_irq_pkg::DATA_W-1:0]    CMD_WDATA,
  input  wire logic [periph_irq_pkg::REASON_W-1:0]  CMD_CAUSE,
  input  wire logic                                 DMA_GO,
  output logic                                      CMD_READY,
  output logic                                      RESP_VALID,
  output logic [periph_irq_pkg::DATA_W-1:0]         RESP_DATA,
  output logic                                      STATUS_VALID,
  output logic [periph_irq_pkg::DATA_W-1:0]         STATUS_WORD
);
  import periph_irq_pkg::*;

  host_state_type    state_ff;
  host_state_type    nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] nxt_wdata;
  logic [DATA_W-1:0] held_ff;
  logic [DATA_W-1:0] nxt_held;
  logic              wr_ff;
  logic              nxt_wr;
  logic              rd_ff;
  logic              nxt_rd;
  logic              svc_ff;
  logic              nxt_svc;
  logic              ready_ff;
  logic              resp_valid_ff;
  logic              nxt_resp_valid;
  logic [DATA_W-1:0] resp_data_ff;
  logic [DATA_W-1:0] nxt_resp_data;
  logic              stat_valid_ff;
  logic              nxt_stat_valid;
  logic [DATA_W-1:0] stat_word_ff;
  logic [DATA_W-1:0] nxt_stat_word;
  logic              wide_ff;
  logic              ack_ff;
  logic              nxt_ack;
  logic [DATA_W-1:0] clean_wdata;

  // Forces reserved positions to their reset value and the burst length even on wide bus.
  always_comb begin
    clean_wdata = CMD_WDATA;
    if (CMD_ADDR == STATUS_OFFSET) begin
      clean_wdata = CMD_WDATA & STATUS_VALID_MASK;
    end else if (CMD_ADDR == BURST_OFFSET) begin
      clean_wdata = DATA_W'(CMD_WDATA[BURST_FIELD_W-1:0]);
      if (WIDE_BUS) begin
        clean_wdata = DATA_W'(CMD_WDATA[BURST_FIELD_W-1:0] & BURST_EVEN_MASK);
      end
    end
  end

  always_comb begin
    nxt_state      = state_ff;
    nxt_addr       = addr_ff;
    nxt_wdata      = wdata_ff;
    nxt_held       = held_ff;
    nxt_wr         = 1'b0;
    nxt_rd         = 1'b0;
    nxt_svc        = svc_ff;
    nxt_resp_valid = 1'b0;
    nxt_resp_data  = resp_data_ff;
    nxt_stat_valid = 1'b0;
    nxt_stat_word  = stat_word_ff;
    nxt_ack        = LINK.dma_request_line && DMA_GO && !ack_ff;
    case (state_ff)
      HOST_IDLE: begin
        if (CMD_VALID) begin
          nxt_svc = 1'b0;
          if (CMD_WRITE && (CMD_ADDR == STATUS_OFFSET) && clean_wdata[DMA_BIT] &&
              (CMD_CAUSE != '0)) begin
            nxt_addr  = REASON_OFFSET;
            nxt_wdata = DATA_W'(CMD_CAUSE);
            nxt_held  = clean_wdata;
            nxt_wr    = 1'b1;
            nxt_state = HOST_REASON;
          end else if (CMD_WRITE) begin
            nxt_addr  = CMD_ADDR;
            nxt_wdata = clean_wdata;
            nxt_wr    = 1'b1;
            nxt_state = HOST_ISSUE;
          end else begin
            nxt_addr  = CMD_ADDR;
            nxt_rd    = 1'b1;
            nxt_state = HOST_WAIT;
          end
        end else if (LINK.irq) begin
          nxt_svc   = 1'b1;
          nxt_addr  = STATUS_OFFSET;
          nxt_rd    = 1'b1;
          nxt_state = HOST_WAIT;
        end
      end
      HOST_REASON: begin
        nxt_addr  = STATUS_OFFSET;
        nxt_wdata = held_ff;
        nxt_wr    = 1'b1;
        nxt_state = HOST_ISSUE;
      end
      HOST_ISSUE: begin
        nxt_resp_valid = 1'b1;
        nxt_resp_data  = '0;
        nxt_state      = HOST_IDLE;
      end
      HOST_WAIT: begin
        if (LINK.reg_rvalid) begin
          if (svc_ff) begin
            nxt_stat_valid = 1'b1;
            nxt_stat_word  = LINK.reg_rdata;
          end else begin
            nxt_resp_valid = 1'b1;
            nxt_resp_data  = LINK.reg_rdata;
          end
          nxt_svc   = 1'b0;
          nxt_state = HOST_IDLE;
        end
      end
      default: begin
        nxt_svc   = 1'b0;
        nxt_state = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_ff      <= HOST_IDLE;
      addr_ff       <= '0;
      wdata_ff      <= '0;
      held_ff       <= '0;
      wr_ff         <= 1'b0;
      rd_ff         <= 1'b0;
      svc_ff        <= 1'b0;
      ready_ff      <= 1'b0;
      resp_valid_ff <= 1'b0;
      resp_data_ff  <= '0;
      stat_valid_ff <= 1'b0;
      stat_word_ff  <= '0;
      wide_ff       <= 1'b0;
      ack_ff        <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      addr_ff       <= nxt_addr;
      wdata_ff      <= nxt_wdata;
      held_ff       <= nxt_held;
      wr_ff         <= nxt_wr;
      rd_ff         <= nxt_rd;
      svc_ff        <= nxt_svc;
      ready_ff      <= (nxt_state == HOST_IDLE);
      resp_valid_ff <= nxt_resp_valid;
      resp_data_ff  <= nxt_resp_data;
      stat_valid_ff <= nxt_stat_valid;
      stat_word_ff  <= nxt_stat_word;
      wide_ff       <= WIDE_BUS;
      ack_ff        <= nxt_ack;
    end
  end

  assign LINK.reg_addr  = addr_ff;
  assign LINK.reg_wdata = wdata_ff;
  assign LINK.reg_wr    = wr_ff;
  assign LINK.reg_rd    = rd_ff;
  assign LINK.bus_wide  = wide_ff;
  assign LINK.dma_ack   = ack_ff;
  assign CMD_READY      = ready_ff;
  assign RESP_VALID     = resp_valid_ff;
  assign RESP_DATA      = resp_data_ff;
  assign STATUS_VALID   = stat_valid_ff;
  assign STATUS_WORD    = stat_word_ff;

endmodule

// *** verif/irq_dma_link_checker.sv ***
// Concurrent checks on the link between the processor side and the device.
`timescale 1ns/100ps
module irq_dma_link_checker (
  input wire logic                                 SYS_CLK,
  input wire logic                                 RST_N,
  input wire logic [periph_irq_pkg::ADDR_W-1:0]    reg_addr,
  input wire logic [periph_irq_pkg::DATA_W-1:0]    reg_wdata,
  input wire logic                                 reg_wr,
  input wire logic                                 reg_rd,
  input wire logic [periph_irq_pkg::DATA_W-1:0]    reg_rdata,
  input wire logic                                 reg_rvalid,
  input wire logic                                 bus_wide,
  input wire logic                                 irq,
  input wire logic                                 dma_request_line,
  input wire logic                                 dma_ack
);
  import periph_irq_pkg::*;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  a_burst_rsvd_read:
    assert property (reg_rd && reg_addr == BURST_OFFSET |=>
                     reg_rvalid && reg_rdata[31:13] == 19'h0)
    else $error("Burst register read has reserved bits set.");
  a_status_rsvd_read:
    assert property (reg_rd && reg_addr == STATUS_OFFSET |=>
                     (reg_rdata & ~STATUS_VALID_MASK) == 32'h0)
    else $error("Status read has reserved bits set.");
  a_irq_tracks_status:
    assert property (reg_rd && reg_addr == STATUS_OFFSET |=> (reg_rdata != 32'h0) == $past(irq))
    else $error("Interrupt level disagrees with status word.");
  a_request_gap_low:
    assert property ($fell(dma_request_line) |-> ##1 !dma_request_line)
    else $error("Request raised again without a gap.");
  a_ack_spacing:
    assert property (dma_ack |-> $past(dma_request_line) && !$past(dma_ack))
    else $error("Acknowledge without request or back to back.");
  a_wide_even_len:
    assert property (reg_wr && reg_addr == BURST_OFFSET && bus_wide |-> reg_wdata[0] == 1'b0)
    else $error("Odd burst length written in wide mode.");
  a_status_wr_rsvd:
    assert property (reg_wr && reg_addr == STATUS_OFFSET |->
                     (reg_wdata & ~STATUS_VALID_MASK) == 32'h0)
    else $error("Status write sets reserved bits.");
  a_burst_wr_rsvd:
    assert property (reg_wr && reg_addr == BURST_OFFSET |-> reg_wdata[31:13] == 19'h0)
    else $error("Burst write sets reserved bits.");
  c_irq_rise: cover property ($rose(irq));
  c_burst_end: cover property ($fell(dma_request_line));
  c_dma_clear: cover property (reg_wr && reg_addr == STATUS_OFFSET && reg_wdata[DMA_BIT]);
endmodule

// *** verif/tb.sv ***
// Self-checking bench joining the processor side and the device through the link.
`timescale 1ns/100ps
module tb;
  import periph_irq_pkg::*;
  logic                sys_clk, rst_n, dma_active, burst_done, wide_bus, dma_go;
  logic                cmd_valid, cmd_write, cmd_ready, resp_valid, status_valid, seen;
  logic [DATA_W-1:0]   ev, cmd_wdata, resp_data, status_word, rd;
  logic [REASON_W-1:0] cause_ev, cmd_cause;
  logic [ADDR_W-1:0]   cmd_addr;
  logic [EP_COUNT-1:0] ep_tx, ep_rx;
  int                  err_total, total_checks, acks, b;
  irq_dma_link_if link ();
  always_comb begin
    for (int i = 0; i < EP_COUNT; i++) begin
      ep_tx[i] = ev[EP_TX_BIT0 + EP_BIT_STRIDE * i];
      ep_rx[i] = ev[EP_RX_BIT0 + EP_BIT_STRIDE * i];
    end
  end
  periph_irq_dma_dev i_periph_irq_dma_dev (.SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(link),
    .EP_TX_EVENT(ep_tx), .EP_RX_EVENT(ep_rx), .SETUP_EVENT(ev[SETUP_BIT]),
    .BUS_RESET_EVENT(ev[BUS_RESET_BIT]), .SOF_EVENT(ev[SOF_BIT]), .PSEUDO_FRAME_START_EVENT_EVENT(ev[PSEUDO_FRAME_START_EVENT_BIT]),
    .SUSPEND_EVENT(ev[SUSPEND_BIT]), .RESUME_EVENT(ev[RESUME_BIT]),
    .HS_STAT_EVENT(ev[HS_STAT_BIT]), .VBUS_EVENT(ev[VBUS_BIT]), .DMA_CAUSE_EVENT(cause_ev),
    .DMA_ACTIVE(dma_active), .BURST_DONE(burst_done));
  periph_irq_dma_host i_periph_irq_dma_host (.SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(link),
    .WIDE_BUS(wide_bus), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
    .CMD_WDATA(cmd_wdata), .CMD_CAUSE(cmd_cause), .DMA_GO(dma_go), .CMD_READY(cmd_ready),
    .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .STATUS_VALID(status_valid),
    .STATUS_WORD(status_word));
  irq_dma_link_checker i_irq_dma_link_checker (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
    .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid),
    .bus_wide(link.bus_wide), .irq(link.irq), .dma_request_line(link.dma_request_line),
    .dma_ack(link.dma_ack));
  task automatic conclude();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [REASON_W-1:0] c);
    logic r;
    int   n;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_cause <= c;
    n = 0;
    do begin
      @(negedge sys_clk);
      r = cmd_ready;
      @(posedge sys_clk);
      n++;
    end while (r !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 50);
    rd = resp_data;
    if (n >= 50) begin
      err_total++;
      $display("Error at %0t: response %h expected %h", $time, 1'b0, 1'b1);
    end
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    cmd(1'b0, a, 32'h0, 8'h00);
    chk(rd, exp);
  endtask
  task automatic pulse(input logic [DATA_W-1:0] v, input logic [REASON_W-1:0] c);
    @(posedge sys_clk);
    ev <= v;
    cause_ev <= c;
    @(posedge sys_clk);
    ev <= 32'h0;
    cause_ev <= 8'h00;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic svc_chk(input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (status_valid !== 1'b1 && n < 20);
    chk(status_word, exp);
  endtask
  task automatic burst();
    int n;
    acks = 0;
    n = 0;
    @(posedge sys_clk);
    dma_active <= 1'b1;
    do begin
      @(negedge sys_clk);
      if (link.dma_ack === 1'b1) acks++;
      n++;
    end while (burst_done !== 1'b1 && n < 200);
    @(posedge sys_clk);
    dma_active <= 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000;
    err_total++;
    conclude();
  end
  initial begin
    {rst_n, dma_active, wide_bus, cmd_valid, cmd_write} = 5'h00;
    {ev, cmd_wdata, cause_ev, cmd_cause, cmd_addr} = '0;
    dma_go = 1'b1;
    err_total = 0;
    total_checks = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd_chk(STATUS_OFFSET, STATUS_RESET);
    rd_chk(REASON_OFFSET, 32'h0);
    rd_chk(BURST_OFFSET, 32'h0);
    rd_chk(8'h20, 32'h0);
    for (b = 0; b < 26; b++) begin
      if (b != DMA_BIT && b != 9) begin
        pulse(32'h1 << b, 8'h00);
        chk({31'h0, link.irq}, 32'h1);
        svc_chk(32'h1 << b);
        cmd(1'b1, STATUS_OFFSET, 32'h0, 8'h00);
        rd_chk(STATUS_OFFSET, 32'h1 << b);
        cmd(1'b1, STATUS_OFFSET, 32'h1 << b, 8'h00);
        rd_chk(STATUS_OFFSET, 32'h0);
        chk({31'h0, link.irq}, 32'h0);
      end
    end
    fork
      cmd(1'b1, STATUS_OFFSET, 32'h1 << SOF_BIT, 8'h00);
      begin
        repeat (2) @(posedge sys_clk);
        ev <= 32'h1 << SOF_BIT;
        @(posedge sys_clk);
        ev <= 32'h0;
      end
    join
    rd_chk(STATUS_OFFSET, 32'h1 << SOF_BIT);
    cmd(1'b1, STATUS_OFFSET, 32'h1 << SOF_BIT, 8'h00);
    rd_chk(STATUS_OFFSET, 32'h0);
    pulse(32'h0, 8'h04);
    rd_chk(STATUS_OFFSET, 32'h1 << DMA_BIT);
    rd_chk(REASON_OFFSET, 32'h4);
    cmd(1'b1, STATUS_OFFSET, 32'h1 << DMA_BIT, 8'h00);
    rd_chk(STATUS_OFFSET, 32'h1 << DMA_BIT);
    cmd(1'b1, STATUS_OFFSET, 32'h1 << DMA_BIT, 8'h04);
    rd_chk(STATUS_OFFSET, 32'h0);
    rd_chk(REASON_OFFSET, 32'h0);
    cmd(1'b1, BURST_OFFSET, 32'h0000_ffff, 8'h00);
    rd_chk(BURST_OFFSET, 32'h0000_1fff);
    cmd(1'b1, BURST_OFFSET, 32'h3, 8'h00);
    burst();
    chk(DATA_W'(acks), 32'h3);
    @(posedge sys_clk);
    wide_bus <= 1'b1;
    cmd(1'b1, BURST_OFFSET, 32'h5, 8'h00);
    rd_chk(BURST_OFFSET, 32'h4);
    burst();
    chk(DATA_W'(acks), 32'h2);
    cmd(1'b1, BURST_OFFSET, 32'h0, 8'h00);
    @(posedge sys_clk);
    dma_active <= 1'b1;
    seen = 1'b0;
    repeat (12) begin
      @(negedge sys_clk);
      if (link.dma_request_line !== 1'b0) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h0);
    @(posedge sys_clk);
    dma_active <= 1'b0;
    conclude();
  end
endmodule
